// ==== bdm_map.svh ====
`ifndef BDM_MAP_SVH
`define BDM_MAP_SVH
// ----------------------------------------
// Bus map
// ----------------------------------------
`define BDM_OWN_SEL 11
`define BDM_FSR_OFS 12'h800
`define BDM_ACC_OFS 12'h804
`define BDM_CMD_OFS 12'h808
`define BDM_STATE_OFS 12'h80C
// ----------------------------------------
// Data memory layout
// ----------------------------------------
`define BDM_SFR_TOP 7'h1F
`define BDM_LOC_STATUS 7'h03
`define BDM_LOC_FSR 7'h04
`define BDM_G0_LO 9'h020
`define BDM_G0_HI 9'h07F
`define BDM_G1_LO 9'h0A0
`define BDM_G1_HI 9'h0EF
`define BDM_G2_LO 9'h120
`define BDM_G2_HI 9'h16F
`define BDM_G1_BASE 9'h060
`define BDM_G2_BASE 9'h0B0
`define BDM_GPR_WORDS 256
// ----------------------------------------
// Status fields
// ----------------------------------------
`define BDM_ST_IRP 7
`define BDM_ST_RP 6:5
`define BDM_ST_TO 4
`define BDM_ST_PD 3
`define BDM_ST_Z 2
`define BDM_ST_DC 1
`define BDM_ST_C 0
`define BDM_ST_RST 8'h18
`define BDM_ST_WMASK 8'hE7
// ----------------------------------------
// Command fields
// ----------------------------------------
`define BDM_CMD_OP 2:0
`define BDM_CMD_IND 3
`define BDM_CMD_SRC 10:4
`define BDM_CMD_DST 18:12
`endif

// ==== bdm_pkg.sv ====
`default_nettype none
package bdm_pkg;
  typedef enum logic [1:0] {
    CS_IDLE = 2'b00,
    CS_EXEC = 2'b01,
    CS_COPY = 2'b10
  } bdm_state_e;
  typedef enum logic [2:0] {
    OP_MOVE_FROM_ACCUM_INSTR = 3'b000,
    OP_MOVF = 3'b001,
    OP_REGISTER_CLEAR_INSTR = 3'b010,
    OP_ADDWF = 3'b011,
    OP_SUBWF = 3'b100,
    OP_COPY = 3'b101,
    OP_WATCHDOG_CLEAR_INSTR = 3'b110,
    OP_SLEEP = 3'b111
  } bdm_op_e;
endpackage : bdm_pkg
`default_nettype wire

// ==== bdm_gen_ram.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "bdm_map.svh"
module bdm_gen_ram (
  input wire logic hclk,
  input wire logic wr_en,
  input wire logic [8:0] wr_loc,
  input wire logic [7:0] wr_data,
  input wire logic [8:0] rd_loc,
  output logic rd_hit,
  output logic [7:0] rd_data
);
  logic [7:0] mem [`BDM_GPR_WORDS];
  logic [8:0] rd_idx;
  logic [8:0] wr_idx;
  logic wr_hit;

  // ----------------------------------------
  // Range decode, packed into one index
  // ----------------------------------------
  function automatic logic [9:0] gpr_map(input logic [8:0] loc);
    gpr_map = 10'h000;
    if (loc >= `BDM_G0_LO && loc <= `BDM_G0_HI) begin
      gpr_map = {1'b1, loc - `BDM_G0_LO};
    end else if (loc >= `BDM_G1_LO && loc <= `BDM_G1_HI) begin
      gpr_map = {1'b1, loc - `BDM_G1_LO + `BDM_G1_BASE};
    end else if (loc >= `BDM_G2_LO && loc <= `BDM_G2_HI) begin
      gpr_map = {1'b1, loc - `BDM_G2_LO + `BDM_G2_BASE};
    end
  endfunction : gpr_map

  assign {rd_hit, rd_idx} = gpr_map(rd_loc);
  assign {wr_hit, wr_idx} = gpr_map(wr_loc);
  // Unmapped reads return zero, not stale words
  assign rd_data = rd_hit ? mem[rd_idx[7:0]] : 8'h00;

  always_ff @(posedge hclk) begin
    if (wr_en && wr_hit) begin
      mem[wr_idx[7:0]] <= wr_data;
    end
  end
endmodule : bdm_gen_ram
`default_nettype wire

// ==== bdm_alu.sv ====
`timescale 1ns/1ps
`default_nettype none
module bdm_alu (
  input wire logic [2:0] op,
  input wire logic [7:0] f_val,
  input wire logic [7:0] w_val,
  output logic [7:0] res,
  output logic z_out,
  output logic dc_out,
  output logic c_out,
  output logic upd_z,
  output logic upd_cdc
);
  logic [8:0] sum;
  logic [4:0] nib;
  logic [7:0] opnd;

  // Subtract as add of two's complement: carries read as inverted borrows
  assign opnd = (op == bdm_pkg::OP_SUBWF) ? ~w_val : w_val;
  assign sum = {1'b0, f_val} + {1'b0, opnd} + {8'h00, op == bdm_pkg::OP_SUBWF};
  assign nib = {1'b0, f_val[3:0]} + {1'b0, opnd[3:0]} + {4'h0, op == bdm_pkg::OP_SUBWF};

  always_comb begin
    res = f_val;
    upd_z = 1'b0;
    upd_cdc = 1'b0;
    case (op)
      bdm_pkg::OP_MOVE_FROM_ACCUM_INSTR: res = w_val;
      bdm_pkg::OP_MOVF: upd_z = 1'b1;
      bdm_pkg::OP_REGISTER_CLEAR_INSTR: begin
        res = 8'h00;
        upd_z = 1'b1;
      end
      bdm_pkg::OP_ADDWF, bdm_pkg::OP_SUBWF: begin
        res = sum[7:0];
        upd_z = 1'b1;
        upd_cdc = 1'b1;
      end
      default: res = f_val;
    endcase
  end

  assign z_out = (res == 8'h00);
  assign dc_out = nib[4];
  assign c_out = sum[8];
endmodule : bdm_alu
`default_nettype wire

// ==== bdm_core_status.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "bdm_map.svh"
module bdm_core_status (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic wdt_timeout,
  output logic [7:0] status_out
);
  logic dph_vld_ff;
  logic dph_wr_ff;
  logic [11:0] dph_addr_ff;
  logic rd_wait_ff;
  logic [31:0] hrdata_ff;
  logic [7:0] status_ff;
  logic [7:0] nxt_status;
  logic [7:0] fsr_ff;
  logic [7:0] acc_ff;
  logic [18:0] cmd_ff;
  logic [8:0] last_loc_ff;
  bdm_pkg::bdm_state_e state_ff;
  logic busy;
  logic wr_fire;
  logic cmd_go;
  logic [2:0] op;
  logic [8:0] exec_loc;
  logic [8:0] rd_loc;
  logic ram_hit;
  logic [7:0] ram_data;
  logic [7:0] loc_data;
  logic mem_we;
  logic [8:0] mem_loc;
  logic [7:0] mem_wd;
  logic [7:0] alu_res;
  logic alu_z;
  logic alu_dc;
  logic alu_c;
  logic upd_z;
  logic upd_cdc;
  logic flags_upd;
  logic do_watchdog_clear_instr;
  logic do_sleep;
  logic st_wr;

  function automatic logic is_loc(input logic [8:0] loc, input logic [6:0] special_registers);
    is_loc = (loc[6:0] == special_registers);
  endfunction : is_loc

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  assign busy = (state_ff != bdm_pkg::CS_IDLE);
  // Reads take at least one wait state, more while a command runs, so a preceding write is always visible
  assign hreadyout = !(dph_vld_ff && (busy || (!dph_wr_ff && rd_wait_ff)));
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;
  assign wr_fire = dph_vld_ff && dph_wr_ff && hreadyout;
  assign cmd_go = wr_fire && (dph_addr_ff == `BDM_CMD_OFS);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_vld_ff <= 1'b0;
      dph_wr_ff <= 1'b0;
      dph_addr_ff <= 12'h000;
    end else if (hready) begin
      dph_vld_ff <= hsel && htrans[1];
      dph_wr_ff <= hwrite;
      dph_addr_ff <= haddr;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_wait_ff <= 1'b0;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      rd_wait_ff <= 1'b1;
    end else if (rd_wait_ff && !busy) begin
      rd_wait_ff <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (dph_vld_ff && !dph_wr_ff && rd_wait_ff && !busy) begin
      case (dph_addr_ff)
        `BDM_FSR_OFS: hrdata_ff <= {24'h00_0000, fsr_ff};
        `BDM_ACC_OFS: hrdata_ff <= {24'h00_0000, acc_ff};
        `BDM_CMD_OFS: hrdata_ff <= {13'h0000, cmd_ff};
        `BDM_STATE_OFS: hrdata_ff <= {21'h00_0000, state_ff, last_loc_ff};
        default: begin
          hrdata_ff <= dph_addr_ff[`BDM_OWN_SEL] ? 32'h0000_0000
                                                 : {24'h00_0000, loc_data};
        end
      endcase
    end
  end

  // ----------------------------------------
  // Data memory access
  // ----------------------------------------
  assign op = cmd_ff[`BDM_CMD_OP];
  always_comb begin
    exec_loc = {status_ff[`BDM_ST_RP], cmd_ff[`BDM_CMD_SRC]};
    if (state_ff == bdm_pkg::CS_COPY) begin
      exec_loc = {status_ff[`BDM_ST_RP], cmd_ff[`BDM_CMD_DST]};
    end else if (cmd_ff[`BDM_CMD_IND]) begin
      exec_loc = {status_ff[`BDM_ST_IRP], fsr_ff};
    end
  end

  // Bus reads and commands never overlap: bus reads wait while busy
  assign rd_loc = busy ? exec_loc : dph_addr_ff[10:2];

  bdm_gen_ram u_ram (
    .hclk(hclk),
    .wr_en(mem_we),
    .wr_loc(mem_loc),
    .wr_data(mem_wd),
    .rd_loc(rd_loc),
    .rd_hit(ram_hit),
    .rd_data(ram_data)
  );

  // Only core registers are modelled; other special locations read zero
  always_comb begin
    loc_data = ram_data;
    if (is_loc(rd_loc, `BDM_LOC_STATUS)) begin
      loc_data = status_ff;
    end else if (is_loc(rd_loc, `BDM_LOC_FSR)) begin
      loc_data = fsr_ff;
    end
  end

  bdm_alu u_alu (
    .op(op),
    .f_val(loc_data),
    .w_val(acc_ff),
    .res(alu_res),
    .z_out(alu_z),
    .dc_out(alu_dc),
    .c_out(alu_c),
    .upd_z(upd_z),
    .upd_cdc(upd_cdc)
  );

  always_comb begin
    mem_we = wr_fire && !dph_addr_ff[`BDM_OWN_SEL];
    mem_loc = dph_addr_ff[10:2];
    mem_wd = hwdata[7:0];
    if (state_ff == bdm_pkg::CS_COPY) begin
      mem_we = 1'b1;
      mem_loc = exec_loc;
      mem_wd = acc_ff;
    end else if (state_ff == bdm_pkg::CS_EXEC) begin
      mem_we = (op == bdm_pkg::OP_MOVE_FROM_ACCUM_INSTR) || (op == bdm_pkg::OP_REGISTER_CLEAR_INSTR) ||
               (op == bdm_pkg::OP_ADDWF) || (op == bdm_pkg::OP_SUBWF);
      mem_loc = exec_loc;
      mem_wd = alu_res;
    end
  end

  // ----------------------------------------
  // Command sequencer
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= bdm_pkg::CS_IDLE;
    end else begin
      case (state_ff)
        bdm_pkg::CS_IDLE: if (cmd_go) begin
          state_ff <= bdm_pkg::CS_EXEC;
        end
        bdm_pkg::CS_EXEC: begin
          state_ff <= (op == bdm_pkg::OP_COPY) ? bdm_pkg::CS_COPY
                                               : bdm_pkg::CS_IDLE;
        end
        bdm_pkg::CS_COPY: state_ff <= bdm_pkg::CS_IDLE;
        default: state_ff <= bdm_pkg::CS_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_ff <= 19'h0_0000;
    end else if (cmd_go) begin
      cmd_ff <= hwdata[18:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last_loc_ff <= 9'h000;
    end else if (busy) begin
      last_loc_ff <= exec_loc;
    end
  end

  // Copy source lands in the accumulator first
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_ff <= 8'h00;
    end else if (state_ff == bdm_pkg::CS_EXEC &&
                 (op == bdm_pkg::OP_COPY || op == bdm_pkg::OP_MOVF)) begin
      acc_ff <= loc_data;
    end else if (wr_fire && dph_addr_ff == `BDM_ACC_OFS) begin
      acc_ff <= hwdata[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fsr_ff <= 8'h00;
    end else if (mem_we && is_loc(mem_loc, `BDM_LOC_FSR)) begin
      fsr_ff <= mem_wd;
    end else if (wr_fire && dph_addr_ff == `BDM_FSR_OFS) begin
      fsr_ff <= hwdata[7:0];
    end
  end

  // ----------------------------------------
  // Status register
  // ----------------------------------------
  assign flags_upd = (state_ff == bdm_pkg::CS_EXEC) && (upd_z || upd_cdc);
  assign do_watchdog_clear_instr = (state_ff == bdm_pkg::CS_EXEC) && (op == bdm_pkg::OP_WATCHDOG_CLEAR_INSTR);
  assign do_sleep = (state_ff == bdm_pkg::CS_EXEC) && (op == bdm_pkg::OP_SLEEP);
  assign st_wr = mem_we && is_loc(mem_loc, `BDM_LOC_STATUS);

  always_comb begin
    nxt_status = status_ff;
    if (st_wr) begin
      nxt_status = (status_ff & ~`BDM_ST_WMASK) | (mem_wd & `BDM_ST_WMASK);
    end
    if (flags_upd) begin
      nxt_status[`BDM_ST_Z] = alu_z;
      if (upd_cdc) begin
        nxt_status[`BDM_ST_DC] = alu_dc;
        nxt_status[`BDM_ST_C] = alu_c;
      end else if (st_wr) begin
        nxt_status[`BDM_ST_DC] = status_ff[`BDM_ST_DC];
        nxt_status[`BDM_ST_C] = status_ff[`BDM_ST_C];
      end
    end
    if (do_watchdog_clear_instr) begin
      nxt_status[`BDM_ST_TO] = 1'b1;
      nxt_status[`BDM_ST_PD] = 1'b1;
    end else if (do_sleep) begin
      nxt_status[`BDM_ST_TO] = 1'b1;
      nxt_status[`BDM_ST_PD] = 1'b0;
    end
    // A time-out in the same cycle as a watchdog clear is not lost
    if (wdt_timeout) begin
      nxt_status[`BDM_ST_TO] = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_ff <= `BDM_ST_RST;
    end else begin
      status_ff <= nxt_status;
    end
  end

  assign status_out = status_ff;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_unmapped_read_zero: assert property (
    dph_vld_ff && !dph_wr_ff && rd_wait_ff && !busy && !dph_addr_ff[`BDM_OWN_SEL] &&
    !ram_hit && !is_loc(rd_loc, `BDM_LOC_STATUS) && !is_loc(rd_loc, `BDM_LOC_FSR)
    |=> hrdata == 32'h0000_0000)
    else $error("unmapped location read nonzero");
  a_ram_not_special: assert property (
    ram_hit |-> rd_loc[6:0] > `BDM_SFR_TOP)
    else $error("general ram hit in special area");
  a_ram_bank3_none: assert property (
    rd_loc[8:7] == 2'b11 |-> !ram_hit)
    else $error("general ram hit in bank 3");
  a_direct_bank: assert property (
    state_ff == bdm_pkg::CS_EXEC && !cmd_ff[`BDM_CMD_IND]
    |-> exec_loc == {status_ff[6:5], cmd_ff[10:4]})
    else $error("direct location not formed from bank selects");
  a_indirect_bank: assert property (
    state_ff == bdm_pkg::CS_EXEC && cmd_ff[`BDM_CMD_IND] |-> exec_loc[8] == status_ff[7])
    else $error("indirect bank not steered by bit 7");
  a_flag_from_alu: assert property (
    st_wr && flags_upd && !wdt_timeout |=> status_ff[2] == $past(alu_z))
    else $error("status write overrode zero flag");
  a_to_pd_locked: assert property (
    st_wr && !do_watchdog_clear_instr && !do_sleep && !wdt_timeout |=> $stable(status_ff[4:3]))
    else $error("instruction write changed time-out or power-down");
  a_clear_status: assert property (
    st_wr && state_ff == bdm_pkg::CS_EXEC && op == bdm_pkg::OP_REGISTER_CLEAR_INSTR && !wdt_timeout
    |=> status_ff[7:5] == 3'b000 && status_ff[2] && $stable(status_ff[4:0] & 5'h1B))
    else $error("clearing status gave wrong pattern");
  a_copy_two_cycles: assert property (
    state_ff == bdm_pkg::CS_EXEC && op == bdm_pkg::OP_COPY
    |=> state_ff == bdm_pkg::CS_COPY ##1 state_ff == bdm_pkg::CS_IDLE)
    else $error("copy did not take two cycles");
  a_sub_borrow: assert property (
    op == bdm_pkg::OP_SUBWF && state_ff == bdm_pkg::CS_EXEC |-> alu_c == (loc_data >= acc_ff))
    else $error("borrow polarity wrong");
  a_timeout_clears: assert property (
    wdt_timeout |=> !status_ff[4])
    else $error("time-out flag not cleared");
  a_sleep_pd: assert property (
    do_sleep && !wdt_timeout |=> !status_ff[3] && status_ff[4])
    else $error("sleep did not set flags");
  a_zero_flag: assert property (
    flags_upd && !st_wr |=> status_ff[2] == ($past(alu_res) == 8'h00))
    else $error("zero flag does not match result");

  c_copy: cover property (state_ff == bdm_pkg::CS_COPY);
  c_status_clear: cover property (st_wr && op == bdm_pkg::OP_REGISTER_CLEAR_INSTR);
  c_bus_read: cover property (dph_vld_ff && !dph_wr_ff && hreadyout);
  c_indirect_bank2: cover property (busy && cmd_ff[`BDM_CMD_IND] && status_ff[7]);
endmodule : bdm_core_status
`default_nettype wire

// ==== banked_data_memory_status_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "bdm_map.svh"
module banked_data_memory_status_tb;
  // ----------------------------------------
  // Clock, reset and bus signals
  // ----------------------------------------
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = 32'h0000_0000;
  logic wdt_timeout = 1'b0;
  wire logic hreadyout;
  wire logic hresp;
  wire logic [31:0] hrdata;
  wire logic [7:0] status_out;
  int n_mismatch = 0;
  int comparisons = 0;
  logic [43:0] exp_q[$];
  logic [43:0] note;
  logic rd_pend = 1'b0;
  logic [7:0] st;

  always #4 hclk = ~hclk;

  bdm_core_status i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .wdt_timeout(wdt_timeout),
    .status_out(status_out)
  );

  // ----------------------------------------
  // Bus master tasks
  // ----------------------------------------
  // Ready is sampled at the falling edge, where it has settled, to avoid edge races
  task automatic wait_ready();
    logic rdy;
    rdy = 1'b0;
    while (!rdy) begin
      @(negedge hclk);
      rdy = (hreadyout === 1'b1);
      @(posedge hclk);
    end
  endtask : wait_ready

  task automatic ahb_xfer(input logic [11:0] addr, input logic wr, input logic [31:0] data);
    hsel <= 1'b1;
    haddr <= addr;
    hwrite <= wr;
    htrans <= 2'b10;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= data;
    wait_ready();
  endtask : ahb_xfer

  task automatic ahb_write(input logic [11:0] addr, input logic [31:0] data);
    ahb_xfer(addr, 1'b1, data);
  endtask : ahb_write

  task automatic ahb_read(input logic [11:0] addr, input logic [31:0] exp);
    exp_q.push_back({addr, exp});
    ahb_xfer(addr, 1'b0, 32'h0000_0000);
  endtask : ahb_read

  function automatic logic [11:0] loc_addr(input logic [8:0] l);
    return {1'b0, l, 2'b00};
  endfunction : loc_addr

  task automatic set_st(input logic [7:0] v);
    ahb_write(12'h00C, {24'h000000, v});
    st = {v[7:5], st[4:3], v[2:0]};
  endtask : set_st

  task automatic st_rd();
    ahb_read(12'h00C, {24'h000000, st});
    comparisons++;
    if (status_out !== st) begin
      n_mismatch++;
      $display("FAIL status_out expected 0x%h seen 0x%h", st, status_out);
    end
  endtask : st_rd

  task automatic cmd(input logic [2:0] op, input logic ind, input logic [6:0] a7,
                     input logic [6:0] d7);
    ahb_write(`BDM_CMD_OFS, {13'h0000, d7, 1'b0, a7, ind, op});
  endtask : cmd

  // ----------------------------------------
  // Read monitor and verdict
  // ----------------------------------------
  always @(negedge hclk) begin
    if (hreadyout === 1'b1) begin
      if (rd_pend) begin
        comparisons++;
        if (hresp !== 1'b0) begin
          n_mismatch++;
          $display("FAIL hresp expected 0 seen %b", hresp);
        end
        if (exp_q.size() == 0) begin
          n_mismatch++;
          $display("FAIL read data expected none seen 0x%h", hrdata);
        end else begin
          note = exp_q.pop_front();
          if (hrdata !== note[31:0]) begin
            n_mismatch++;
            $display("FAIL read 0x%h expected 0x%h seen 0x%h", note[43:32], note[31:0], hrdata);
          end
        end
      end
      rd_pend = hsel && htrans[1] && !hwrite;
    end
  end

  task automatic tally_and_finish();
    if (exp_q.size() != 0) n_mismatch++;
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  // Whole run is a few hundred cycles; this is far beyond it
  initial begin
    #(20000 * 8);
    n_mismatch++;
    tally_and_finish();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] r;
    logic [8:0] locs [12];
    logic [7:0] vals [12];
    int k;
    void'($urandom(32'h6EF00892));
    locs = '{9'h020, 9'h07F, 9'h050, 9'h0A0, 9'h0EF, 9'h120, 9'h16F,
             9'h01F, 9'h09F, 9'h0F0, 9'h170, 9'h1A0};
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    st = 8'h18;
    st_rd();
    // First seven are general RAM, the rest must read zero
    for (k = 0; k < 12; k++) begin
      vals[k] = $urandom;
      r = $urandom;
      ahb_write(loc_addr(locs[k]), {r, r, r, vals[k]});
    end
    for (k = 0; k < 12; k++) begin
      ahb_read(loc_addr(locs[k]), (k < 7) ? {24'h000000, vals[k]} : 32'h0);
    end
    for (k = 0; k < 4; k++) begin
      a = $urandom;
      set_st({1'b0, k[1:0], 5'h00});
      ahb_write(`BDM_ACC_OFS, {24'h000000, a});
      cmd(bdm_pkg::OP_MOVE_FROM_ACCUM_INSTR, 1'b0, 7'h30, 7'h00);
      ahb_read({1'b0, k[1:0], 7'h30, 2'b00}, (k == 3) ? 32'h0 : {24'h000000, a});
    end
    // Direct selects set to bank 3 to show indirect ignores them
    for (k = 0; k < 2; k++) begin
      a = $urandom;
      set_st({k[0], 2'b11, 5'h00});
      ahb_write(`BDM_FSR_OFS, 32'h0000_0045);
      ahb_write(`BDM_ACC_OFS, {24'h000000, a});
      cmd(bdm_pkg::OP_MOVE_FROM_ACCUM_INSTR, 1'b1, 7'h00, 7'h00);
      ahb_read(loc_addr({k[0], 8'h45}), {24'h000000, a});
    end
    ahb_read(`BDM_FSR_OFS, 32'h0000_0045);
    set_st(8'h00);
    a = $urandom;
    ahb_write(loc_addr(9'h021), {24'h000000, a});
    cmd(bdm_pkg::OP_COPY, 1'b0, 7'h21, 7'h22);
    ahb_read(loc_addr(9'h022), {24'h000000, a});
    ahb_read(`BDM_ACC_OFS, {24'h000000, a});
    // Last two passes use equal operands; the last, a subtract, hits the zero and no-borrow edge
    for (k = 0; k < 8; k++) begin
      a = $urandom;
      b = (k >= 6) ? a : 8'($urandom);
      ahb_write(loc_addr(9'h025), {24'h000000, a});
      ahb_write(`BDM_ACC_OFS, {24'h000000, b});
      if (k[0]) begin
        cmd(bdm_pkg::OP_SUBWF, 1'b0, 7'h25, 7'h00);
        r = a - b;
        st[1:0] = {a[3:0] >= b[3:0], a >= b};
      end else begin
        cmd(bdm_pkg::OP_ADDWF, 1'b0, 7'h25, 7'h00);
        r = a + b;
        st[1:0] = {(5'(a[3:0]) + 5'(b[3:0])) > 5'd15, (9'(a) + 9'(b)) > 9'd255};
      end
      st[2] = (r == 8'h00);
      ahb_read(loc_addr(9'h025), {24'h000000, r});
      st_rd();
    end
    a = st;
    b = $urandom;
    ahb_write(`BDM_ACC_OFS, {24'h000000, b});
    cmd(bdm_pkg::OP_ADDWF, 1'b0, 7'h03, 7'h00);
    r = a + b;
    st = {r[7:5], st[4:3], r == 8'h00, (5'(a[3:0]) + 5'(b[3:0])) > 5'd15,
          (9'(a) + 9'(b)) > 9'd255};
    st_rd();
    set_st(8'hE7);
    st_rd();
    cmd(bdm_pkg::OP_REGISTER_CLEAR_INSTR, 1'b0, 7'h03, 7'h00);
    st = {3'b000, st[4:3], 1'b1, st[1:0]};
    st_rd();
    set_st(8'h00);
    ahb_write(loc_addr(9'h026), 32'h0000_0000);
    ahb_write(`BDM_ACC_OFS, 32'h0000_005A);
    cmd(bdm_pkg::OP_MOVF, 1'b0, 7'h26, 7'h00);
    st[2] = 1'b1;
    ahb_read(`BDM_ACC_OFS, 32'h0000_0000);
    st_rd();
    cmd(bdm_pkg::OP_SLEEP, 1'b0, 7'h00, 7'h00);
    st[4:3] = 2'b10;
    st_rd();
    wdt_timeout <= 1'b1;
    @(posedge hclk);
    wdt_timeout <= 1'b0;
    st[4] = 1'b0;
    st_rd();
    cmd(bdm_pkg::OP_WATCHDOG_CLEAR_INSTR, 1'b0, 7'h00, 7'h00);
    st[4:3] = 2'b11;
    st_rd();
    ahb_write(12'h810, $urandom);
    ahb_read(12'h810, 32'h0000_0000);
    repeat (2) @(posedge hclk);
    tally_and_finish();
  end
endmodule : banked_data_memory_status_tb
`default_nettype wire
